// File: bus_cycle_pkg.sv
/*
  Shared constants and types for the multiplexed external bus-cycle logic.
  Assumes a single 40 MHz clock; one bus clock state spans two clock cycles.
*/
package bus_cycle_pkg;

  // Bus widths and the synchroniser vector width
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned SYNC_W   = 10;

  // Positions inside the synchroniser vector
  localparam int unsigned SYNC_READY_BIT = 8;
  localparam int unsigned SYNC_HOLD_BIT  = 9;

  // Phase within one clock state
  localparam logic PHASE_FIRST = 1'b0;
  localparam logic PHASE_LAST  = 1'b1;

  // Reset values of the pins
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [2:0] STATUS_RESET = 3'h0;

  // Cycle-type codes {io_mem, status_high, status_low}
  localparam logic [2:0] CODE_MEM_WR  = 3'h1;
  localparam logic [2:0] CODE_MEM_RD  = 3'h2;
  localparam logic [2:0] CODE_OPFETCH = 3'h3;
  localparam logic [2:0] CODE_IO_WR   = 3'h5;
  localparam logic [2:0] CODE_IO_RD   = 3'h6;
  localparam logic [2:0] CODE_INTA    = 3'h7;
  localparam logic [2:0] CODE_HALT    = 3'h0;

  typedef enum logic [2:0] {
    KIND_MEM_RD,
    KIND_MEM_WR,
    KIND_IO_RD,
    KIND_IO_WR,
    KIND_OPFETCH,
    KIND_INTA
  } cycle_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_WAIT,
    ST_T3,
    ST_HOLD,
    ST_HALT
  } bus_state_t;

endpackage

// File: pin_sync.sv
/*
  Two-stage synchroniser for asynchronous pin inputs.
  Assumes inputs change independently of clk_i; stage one feeds only stage two.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 10
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // Two flip-flops per bit
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // pin_sync

// File: bus_cycle_ctrl.sv
/*
  External bus-cycle sequencer: high address lines, multiplexed low address
  and data bus, address latch strobe, cycle status, ready waits, hold and halt.
  Assumes a core on the same clock issues one request at a time; ready, hold
  and the bus input are pins and are synchronised before use.
*/
`timescale 1ns/1ps
module bus_cycle_ctrl
  import bus_cycle_pkg::*;
(
  // Clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             reset_i,
  input  wire logic                             ce_i,
  // Core request side
  input  wire logic                             req_valid_i,
  input  wire bus_cycle_pkg::cycle_kind_t       req_kind_i,
  input  wire logic [bus_cycle_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic [bus_cycle_pkg::BYTE_W-1:0] req_wdata_i,
  input  wire logic                             halt_i,
  output logic                                  req_ready_o,
  output logic                                  done_o,
  output logic      [bus_cycle_pkg::BYTE_W-1:0] rdata_o,
  // High address lines
  output logic      [bus_cycle_pkg::BYTE_W-1:0] high_address_lines_o,
  output logic                                  high_address_oe_o,
  // Multiplexed bus
  input  wire logic [bus_cycle_pkg::BYTE_W-1:0] low_addr_data_bus_i,
  output logic      [bus_cycle_pkg::BYTE_W-1:0] low_addr_data_bus_o,
  output logic                                  low_addr_data_bus_oe_o,
  // Strobes
  output logic                                  ale_o,
  output logic                                  rd_n_o,
  output logic                                  rd_oe_o,
  output logic                                  wr_n_o,
  output logic                                  wr_oe_o,
  // Cycle status
  output logic                                  io_mem_o,
  output logic                                  io_mem_oe_o,
  output logic                                  cycle_status_high_o,
  output logic                                  cycle_status_low_o,
  // Bus arbitration
  input  wire logic                             ready_i,
  input  wire logic                             hold_i,
  output logic                                  bus_release_grant_o
);
  import bus_cycle_pkg::*;

  bus_state_t              state_q, state_d;
  logic                    phase_q, phase_d;
  cycle_kind_t             kind_q, kind_d;
  logic [ADDR_W-1:0]       addr_q, addr_d;
  logic [BYTE_W-1:0]       wdata_q, wdata_d;
  logic [SYNC_W-1:0]       sync_s;
  logic                    ready_s, hold_s, accept, is_write, is_read, in_xfer;
  logic [2:0]              code_d;

  // Pin synchroniser
  pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .async_i ({hold_i, ready_i, low_addr_data_bus_i}),
    .sync_o  (sync_s)
  );

  assign ready_s = sync_s[SYNC_READY_BIT];
  assign hold_s  = sync_s[SYNC_HOLD_BIT];
  assign accept  = (state_q == ST_IDLE) && req_valid_i && !hold_s && !halt_i;

  // Cycle code of a kind
  function automatic logic [2:0] kind_code(input cycle_kind_t k);
    unique case (k)
      KIND_MEM_WR:  kind_code = CODE_MEM_WR;
      KIND_IO_WR:   kind_code = CODE_IO_WR;
      KIND_IO_RD:   kind_code = CODE_IO_RD;
      KIND_OPFETCH: kind_code = CODE_OPFETCH;
      KIND_MEM_RD:  kind_code = CODE_MEM_RD;
      KIND_INTA:    kind_code = CODE_INTA;
      default:      kind_code = CODE_HALT;
    endcase
  endfunction

  // Next state
  always_comb begin
    state_d = state_q;
    phase_d = ~phase_q;
    unique case (state_q)
      ST_IDLE: begin
        phase_d = PHASE_FIRST;
        if (hold_s) begin
          state_d = ST_HOLD;
        end else if (halt_i) begin
          state_d = ST_HALT;
        end else if (accept) begin
          state_d = ST_T1;
        end
      end
      ST_T1: begin
        if (phase_q == PHASE_LAST) begin
          state_d = ST_T2;
        end
      end
      ST_T2, ST_WAIT: begin
        if (phase_q == PHASE_LAST) begin
          state_d = ready_s ? ST_T3 : ST_WAIT;
        end
      end
      ST_T3: begin
        if (phase_q == PHASE_LAST) begin
          state_d = ST_IDLE;
        end
      end
      ST_HOLD: begin
        phase_d = PHASE_FIRST;
        if (!hold_s) begin
          state_d = ST_IDLE;
        end
      end
      ST_HALT: begin
        phase_d = PHASE_FIRST;
        if (hold_s) begin
          state_d = ST_HOLD;
        end else if (!halt_i) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // Request capture
  always_comb begin
    kind_d  = accept ? req_kind_i : kind_q;
    addr_d  = accept ? req_addr_i : addr_q;
    wdata_d = accept ? req_wdata_i : wdata_q;
    code_d  = kind_code(kind_d);
  end

  assign is_write = (kind_d == KIND_MEM_WR) || (kind_d == KIND_IO_WR);
  assign is_read  = !is_write && (kind_d != KIND_INTA);
  assign in_xfer  = (state_d == ST_T2) || (state_d == ST_WAIT) || (state_d == ST_T3);

  // Sequencer state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      phase_q <= PHASE_FIRST;
      kind_q  <= KIND_MEM_RD;
      addr_q  <= '0;
      wdata_q <= BYTE_RESET;
    end else if (ce_i) begin
      state_q <= state_d;
      phase_q <= phase_d;
      kind_q  <= kind_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  // Address and data pins
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      high_address_lines_o   <= BYTE_RESET;
      high_address_oe_o      <= 1'b0;
      low_addr_data_bus_o    <= BYTE_RESET;
      low_addr_data_bus_oe_o <= 1'b0;
    end else if (ce_i) begin
      high_address_oe_o <= (state_d == ST_T1) || in_xfer;
      if (accept) begin
        high_address_lines_o <= (req_kind_i == KIND_IO_RD || req_kind_i == KIND_IO_WR)
                                ? req_addr_i[7:0] : req_addr_i[15:8];
      end
      low_addr_data_bus_oe_o <= (state_d == ST_T1) || (in_xfer && is_write);
      low_addr_data_bus_o    <= (state_d == ST_T1) ? addr_d[7:0] : wdata_d;
    end
  end

  // Strobes and status
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ale_o               <= 1'b0;
      rd_n_o              <= 1'b1;
      rd_oe_o             <= 1'b0;
      wr_n_o              <= 1'b1;
      wr_oe_o             <= 1'b0;
      io_mem_o            <= 1'b0;
      io_mem_oe_o         <= 1'b0;
      cycle_status_high_o <= 1'b0;
      cycle_status_low_o  <= 1'b0;
      bus_release_grant_o <= 1'b0;
    end else if (ce_i) begin
      ale_o   <= (state_d == ST_T1) && (phase_d == PHASE_FIRST);
      rd_oe_o <= (state_d != ST_HOLD) && (state_d != ST_HALT);
      wr_oe_o <= (state_d != ST_HOLD) && (state_d != ST_HALT);
      rd_n_o  <= !(in_xfer && is_read);
      wr_n_o  <= !(in_xfer && is_write);
      io_mem_oe_o         <= (state_d != ST_HOLD) && (state_d != ST_HALT);
      bus_release_grant_o <= (state_d == ST_HOLD);
      if (state_d == ST_HALT || state_d == ST_HOLD) begin
        {io_mem_o, cycle_status_high_o, cycle_status_low_o} <= CODE_HALT;
      end else if (state_d == ST_T1 && phase_d == PHASE_FIRST) begin
        {io_mem_o, cycle_status_high_o, cycle_status_low_o} <= code_d;
      end
    end
  end

  // Core handshake and read data
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_ready_o <= 1'b0;
      done_o      <= 1'b0;
      rdata_o     <= BYTE_RESET;
    end else if (ce_i) begin
      req_ready_o <= (state_d == ST_IDLE);
      done_o      <= (state_q == ST_T3) && (phase_q == PHASE_LAST);
      if ((state_q == ST_T3) && (phase_q == PHASE_LAST) && is_read) begin
        rdata_o <= sync_s[BYTE_W-1:0];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  hi_addr_float_a: assert property ((state_q == ST_HOLD || state_q == ST_HALT)
    |-> !high_address_oe_o) else $error("high address driven while released");
  hi_addr_drive_a: assert property ((state_q == ST_T1) |-> high_address_oe_o
    && (high_address_lines_o == ((kind_q == KIND_IO_RD || kind_q == KIND_IO_WR)
    ? addr_q[7:0] : addr_q[15:8]))) else $error("high address wrong in first state");
  low_addr_out_a: assert property ((state_q == ST_T1) |->
    low_addr_data_bus_oe_o && low_addr_data_bus_o == addr_q[7:0])
    else $error("low address missing in first state");
  ale_pulse_a: assert property ((state_q == ST_T1 && phase_q == PHASE_FIRST) |->
    ale_o ##1 !ale_o) else $error("latch strobe not one phase");
  ale_stable_a: assert property ($fell(ale_o) |->
    low_addr_data_bus_oe_o && $stable(low_addr_data_bus_o)) else $error("address moved at strobe");
  write_data_a: assert property ((state_q == ST_T2 && kind_q == KIND_MEM_WR) |->
    low_addr_data_bus_oe_o && low_addr_data_bus_o == wdata_q && !wr_n_o)
    else $error("write data not driven");
  code_memwr_a: assert property ((state_q == ST_T1 && kind_q == KIND_MEM_WR) |->
    {io_mem_o, cycle_status_high_o, cycle_status_low_o} == 3'h1) else $error("bad write code");
  code_read_a: assert property ((state_q == ST_T1 && kind_q == KIND_IO_RD) |->
    {io_mem_o, cycle_status_high_o, cycle_status_low_o} == 3'h6) else $error("bad port read code");
  code_memrd_a: assert property ((state_q == ST_T1 && kind_q == KIND_MEM_RD) |->
    {io_mem_o, cycle_status_high_o, cycle_status_low_o} == 3'h2) else $error("bad read code");
  halt_status_a: assert property ((state_q == ST_HALT) |-> !io_mem_oe_o
    && !cycle_status_high_o && !cycle_status_low_o) else $error("bad halt status");
  status_hold_a: assert property ((state_q == ST_T2 || state_q == ST_WAIT || state_q == ST_T3)
    |-> $stable({io_mem_o, cycle_status_high_o, cycle_status_low_o})) else $error("status moved");
  ready_wait_a: assert property ((state_q != ST_T3 && state_q != ST_IDLE
    && state_q == ST_T2 && phase_q == PHASE_LAST && !ready_s) |=> state_q == ST_WAIT ##2 !done_o)
    else $error("wait not inserted");
  hold_float_a: assert property (bus_release_grant_o |-> !rd_oe_o && !wr_oe_o
    && !low_addr_data_bus_oe_o && !io_mem_oe_o && !high_address_oe_o) else $error("bus not released");

  read_cycle_c: cover property (state_q == ST_T3 && kind_q == KIND_MEM_RD ##1 done_o);
  wait_cycle_c: cover property (state_q == ST_WAIT ##2 state_q == ST_T3);
  hold_enter_c: cover property ($rose(bus_release_grant_o));
  halt_enter_c: cover property (state_q == ST_IDLE ##1 state_q == ST_HALT);

endmodule // bus_cycle_ctrl

// File: bus_party.sv
/*
  Model of the memories and ports on the far side of the multiplexed bus.
  Assumes the bench resolves the bus wire and pulls the floated strobes high.
*/
`timescale 1ns/1ps
module bus_party (
  // Clock
  input  wire logic       clk_i,
  // Bus pins
  input  wire logic       ale_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] bus_i,
  input  wire logic [2:0] status_i,
  // Wait control
  input  wire logic [3:0] wait_i,
  output logic            ready_o,
  // Read data
  output logic            drive_o,
  output logic [7:0]      data_o,
  // Latched address and status
  output logic [7:0]      latch_addr_o,
  output logic [2:0]      latch_status_o
);
  logic [7:0] mem_q [256];
  logic [3:0] cnt_q;

  initial begin
    cnt_q = 4'h0;
    latch_addr_o = 8'h00;
    latch_status_o = 3'h0;
    for (int i = 0; i < 256; i++) mem_q[i] = ~8'(i);
  end

  // Low address and status captured on the strobe's falling edge
  always @(negedge ale_i) begin
    latch_addr_o = bus_i;
    latch_status_o = status_i;
  end

  // Clocks since a strobe fell; write data taken while the write strobe is low
  always @(posedge clk_i) begin
    if (rd_n_i && wr_n_i) cnt_q <= 4'h0;
    else if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
    if (!wr_n_i) mem_q[latch_addr_o] <= bus_i;
  end

  assign ready_o = (cnt_q >= wait_i);
  assign drive_o = !rd_n_i;
  assign data_o  = mem_q[latch_addr_o];
endmodule // bus_party

// File: tb_top.sv
/*
  Self-checking bench for the bus-cycle sequencer with a far-side party model.
  Assumes one 40 MHz clock; ce_i is tied high; inputs change at falling edges.
*/
`timescale 1ns/1ps
module tb_top;
  import bus_cycle_pkg::*;
  logic        clk_i, reset_i, req_valid_i, halt_i, hold_i;
  cycle_kind_t req_kind_i;
  logic [15:0] req_addr_i;
  logic [7:0]  req_wdata_i, rdata_o, high_o, ad_o, p_data, flt_q, lat_addr;
  logic [3:0]  wait_q;
  logic        req_ready_o, done_o, high_oe, ad_oe, ale_o, rd_n_o, rd_oe_o, wr_n_o, wr_oe_o;
  logic        io_mem_o, io_mem_oe_o, st_hi, st_lo, ready_w, grant_o, p_drive;
  logic [2:0]  lat_st;
  wire  [7:0]  bus_w    = ad_oe ? ad_o : (p_drive ? p_data : flt_q);
  wire  [2:0]  status_w = {io_mem_o, st_hi, st_lo};
  int          mismatches, compares, lat0, lat1;

  bus_cycle_ctrl u_bus_cycle_ctrl (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .req_valid_i(req_valid_i),
    .req_kind_i(req_kind_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .halt_i(halt_i), .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .high_address_lines_o(high_o), .high_address_oe_o(high_oe),
    .low_addr_data_bus_i(bus_w), .low_addr_data_bus_o(ad_o), .low_addr_data_bus_oe_o(ad_oe),
    .ale_o(ale_o), .rd_n_o(rd_n_o), .rd_oe_o(rd_oe_o), .wr_n_o(wr_n_o), .wr_oe_o(wr_oe_o),
    .io_mem_o(io_mem_o), .io_mem_oe_o(io_mem_oe_o), .cycle_status_high_o(st_hi),
    .cycle_status_low_o(st_lo), .ready_i(ready_w), .hold_i(hold_i),
    .bus_release_grant_o(grant_o)
  );

  bus_party u_bus_party (
    .clk_i(clk_i), .ale_i(ale_o), .rd_n_i(rd_n_o | ~rd_oe_o), .wr_n_i(wr_n_o | ~wr_oe_o),
    .bus_i(bus_w), .status_i(status_w), .wait_i(wait_q), .ready_o(ready_w),
    .drive_o(p_drive), .data_o(p_data), .latch_addr_o(lat_addr), .latch_status_o(lat_st)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Released bus lines show a pattern that changes every cycle
  initial flt_q = 8'h5A;
  always @(posedge clk_i) flt_q <= ~flt_q;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [2:0] code_of(input cycle_kind_t k);
    case (k)
      KIND_MEM_WR:  return 3'b001;
      KIND_MEM_RD:  return 3'b010;
      KIND_IO_WR:   return 3'b101;
      KIND_IO_RD:   return 3'b110;
      KIND_OPFETCH: return 3'b011;
      default:      return 3'b111;
    endcase
  endfunction

  // One machine cycle, checked at the latch strobe and at completion
  task automatic run(input cycle_kind_t k, input logic [15:0] a, input logic [7:0] exp_rd,
                     output int lat);
    int n;
    logic io;
    io = (k == KIND_IO_RD || k == KIND_IO_WR);
    n = 0;
    while (req_ready_o !== 1'b1 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 60) begin
      mismatches++;
      conclude();
    end
    req_kind_i = k;
    req_addr_i = a;
    req_valid_i = 1'b1;
    @(negedge clk_i);
    req_valid_i = 1'b0;
    lat = 1;
    while (done_o !== 1'b1 && lat < 100) begin
      if (ale_o === 1'b1) begin
        chk(high_oe, 1'b1);
        chk(high_o, io ? a[7:0] : a[15:8]);
        chk(bus_w, a[7:0]);
      end
      chk(status_w, code_of(k));
      @(negedge clk_i);
      lat++;
    end
    if (lat >= 100) begin
      mismatches++;
      conclude();
    end
    chk(lat_addr, a[7:0]);
    chk(lat_st, code_of(k));
    if (k != KIND_INTA && !(k == KIND_MEM_WR || k == KIND_IO_WR)) chk(rdata_o, exp_rd);
  endtask

  task automatic s_reset();
    repeat (10) @(negedge clk_i);
    chk({high_oe, ad_oe, io_mem_oe_o, grant_o}, 4'h0);
    chk(ale_o, 1'b0);
    reset_i = 1'b0;
  endtask

  // Back-to-back writes then reads, the party drives the read data
  task automatic s_mem();
    req_wdata_i = 8'hC3;
    run(KIND_MEM_WR, 16'hA53C, 8'h00, lat0);
    req_wdata_i = 8'h96;
    run(KIND_MEM_WR, 16'h12F0, 8'h00, lat0);
    run(KIND_MEM_RD, 16'hA53C, 8'hC3, lat0);
    run(KIND_MEM_RD, 16'h12F0, 8'h96, lat0);
  endtask

  task automatic s_codes();
    req_wdata_i = 8'h11;
    run(KIND_IO_WR, 16'h007E, 8'h00, lat1);
    run(KIND_IO_RD, 16'h007E, 8'h11, lat1);
    run(KIND_OPFETCH, 16'h3481, 8'h7E, lat1);
    run(KIND_INTA, 16'h0000, 8'h00, lat1);
  endtask

  task automatic s_wait();
    wait_q = 4'h3;
    run(KIND_MEM_RD, 16'hA53C, 8'hC3, lat1);
    chk(lat1 > lat0, 1'b1);
    chk(16'((lat1 - lat0) % 2), 16'h0);
    wait_q = 4'h0;
  endtask

  // Bounded wait for the grant to reach a level; a timeout ends the run
  task automatic wait_grant(input logic lvl);
    int n;
    n = 0;
    while (grant_o !== lvl && n < 12) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 12) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic s_hold();
    int n;
    req_wdata_i = 8'h5C;
    fork
      run(KIND_MEM_WR, 16'hBE44, 8'h00, lat1);
      begin
        repeat (2) @(negedge clk_i);
        hold_i = 1'b1;
        n = 0;
        while (done_o !== 1'b1 && n < 100) begin
          chk(grant_o, 1'b0);
          @(negedge clk_i);
          n++;
        end
        if (n >= 100) begin
          mismatches++;
          conclude();
        end
      end
    join
    wait_grant(1'b1);
    chk(grant_o, 1'b1);
    chk({high_oe, ad_oe, rd_oe_o, wr_oe_o, io_mem_oe_o}, 5'h00);
    chk(ale_o, 1'b0);
    hold_i = 1'b0;
    wait_grant(1'b0);
    chk(grant_o, 1'b0);
    run(KIND_MEM_RD, 16'hBE44, 8'h5C, lat1);
  endtask

  task automatic s_halt();
    halt_i = 1'b1;
    repeat (8) @(negedge clk_i);
    chk({high_oe, io_mem_oe_o}, 2'b00);
    chk({st_hi, st_lo, ale_o}, 3'b000);
    halt_i = 1'b0;
    run(KIND_MEM_RD, 16'h12F0, 8'h96, lat1);
  endtask

  initial begin
    mismatches = 0;
    compares = 0;
    reset_i = 1'b1;
    req_valid_i = 1'b0;
    req_kind_i = KIND_MEM_RD;
    req_addr_i = 16'h0000;
    req_wdata_i = 8'h00;
    halt_i = 1'b0;
    hold_i = 1'b0;
    wait_q = 4'h0;
    s_reset();
    s_mem();
    s_codes();
    s_wait();
    s_hold();
    s_halt();
    conclude();
  end
endmodule // tb_top
